// >>> prt_board.sv
// Board model: senses driven pins, drives the rest
`timescale 1ns/1ps
module prt_board (
    // Pins
    input  wire prt_pkg::prt_pin_s pin_out,
    input  wire logic [7:0]        board_drive,
    output logic      [7:0]        pin_in
);
    import prt_pkg::*;
    // Board drives only pins the port leaves undriven
    assign pin_in = (pin_out.oe & pin_out.level)
                  | (~pin_out.oe & board_drive);
endmodule

// >>> prt_pkg.sv
// Package for the eight-pin port: addresses, reset values, carriers
package prt_pkg;
    localparam int          PRT_WIDTH       = 8;
    localparam logic [15:0] PRT_DATA_ADDR   = 16'hFFD6;
    localparam logic [15:0] PRT_DIR_ADDR    = 16'hFFE6;
    localparam logic [7:0]  PRT_DATA_RESET  = 8'h00;
    localparam logic [7:0]  PRT_DIR_RESET   = 8'h00;
    localparam logic [7:0]  PRT_DIR_READ    = 8'hFF;
    localparam logic [7:0]  PRT_UNMAP_READ  = 8'hFF;

    // One byte access from the peripheral bus
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } prt_req_s;

    // Pin drive group
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } prt_pin_s;
endpackage

// >>> prt_port.sv
// Eight-pin port with data latch and write-only direction register
`timescale 1ns/1ps
module prt_port (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Peripheral bus
    input  wire prt_pkg::prt_req_s  bus_req,
    output logic [7:0]              bus_rdata,
    output logic                    bus_rvalid,
    // Pins
    input  wire logic [7:0]         port_three_pin_in,
    output prt_pkg::prt_pin_s       port_three_pin_out
);
    import prt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [7:0] port_three_data_reg;
    logic [7:0] port_three_direction_reg;
    logic [7:0] pin_sync;
    logic [7:0] next_data;
    logic [7:0] next_dir;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    prt_pin_s   next_pins;
    logic [7:0] data_view;

    // Pin levels come from outside the clock domain
    prt_sync #(
        .WIDTH(PRT_WIDTH)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (port_three_pin_in),
        .sync_out (pin_sync)
    );

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction

    // Ports are one byte wide, so the package width must match them
    if (PRT_WIDTH != 8)
    begin : g_width_check
        $error("port width must be eight");
    end

    ////////////////////////////////////////////////////////////////////
    // Read view per pin: latch for outputs, synchronised level for inputs
    for (genvar g = 0; g < PRT_WIDTH; g++)
    begin : g_view
        assign data_view[g] = port_three_direction_reg[g]
                            ? port_three_data_reg[g]
                            : pin_sync[g];
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes
    always_comb
    begin
        next_data = port_three_data_reg;
        next_dir  = port_three_direction_reg;
        if (bus_req.wr && hit(bus_req.addr, PRT_DATA_ADDR))
            next_data = bus_req.wdata;
        if (bus_req.wr && hit(bus_req.addr, PRT_DIR_ADDR))
            next_dir = bus_req.wdata;
    end

    // Read path; mixing per bit is what makes blind bit-set risky
    always_comb
    begin
        next_rvalid = bus_req.rd;
        next_rdata  = PRT_UNMAP_READ;
        if (hit(bus_req.addr, PRT_DATA_ADDR))
            next_rdata = data_view;
        else if (hit(bus_req.addr, PRT_DIR_ADDR))
            next_rdata = PRT_DIR_READ;
        if (!bus_req.rd)
            next_rdata = '0;
    end

    // Pin drive, bit n to pin n
    always_comb
    begin
        next_pins.oe    = next_dir;
        next_pins.level = next_data & next_dir;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_three_data_reg      <= PRT_DATA_RESET;
            port_three_direction_reg <= PRT_DIR_RESET;
            bus_rdata                <= '0;
            bus_rvalid               <= 1'b0;
            port_three_pin_out       <= '0;
        end
        else
        begin
            port_three_data_reg      <= next_data;
            port_three_direction_reg <= next_dir;
            bus_rdata                <= next_rdata;
            bus_rvalid               <= next_rvalid;
            port_three_pin_out       <= next_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_dir_read;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DIR_ADDR
            |=> bus_rvalid && bus_rdata == 8'hFF;
    endproperty
    dir_reads_ones_a: assert property (p_dir_read)
        else $error("direction read not all ones");

    // Read checks look one edge back, where the read was decoded
    out_bit_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DATA_ADDR
            |=> ((bus_rdata ^ $past(port_three_data_reg))
                 & $past(port_three_direction_reg)) == 8'h00)
        else $error("output bit read not latch");

    in_bit_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DATA_ADDR
            |=> ((bus_rdata ^ $past(pin_sync))
                 & ~$past(port_three_direction_reg)) == 8'h00)
        else $error("input bit read not pin");

    data_write_all_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == PRT_DATA_ADDR
            |=> port_three_data_reg == $past(bus_req.wdata))
        else $error("data write lost bits");

    data_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(bus_req.wr && bus_req.addr == PRT_DATA_ADDR)
            |=> $stable(port_three_data_reg))
        else $error("data latch changed unasked");

    pin_level_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        port_three_pin_out.level
            == (port_three_data_reg & port_three_direction_reg))
        else $error("pin level wrong");

    pin_drive_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == PRT_DATA_ADDR
            |=> port_three_pin_out.level
                == ($past(bus_req.wdata) & port_three_direction_reg))
        else $error("written level not driven");

    level_oe_only_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (port_three_pin_out.level & ~port_three_pin_out.oe) == 8'h00)
        else $error("level shown on undriven pin");

    pin_enable_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == PRT_DIR_ADDR
            |=> port_three_pin_out.oe == $past(bus_req.wdata))
        else $error("direction not applied");

    oe_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        port_three_pin_out.oe == port_three_direction_reg)
        else $error("enable differs from direction");

    dir_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == PRT_DIR_ADDR
            |=> port_three_direction_reg == $past(bus_req.wdata))
        else $error("direction write lost bits");

    dir_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(bus_req.wr && bus_req.addr == PRT_DIR_ADDR)
            |=> $stable(port_three_direction_reg))
        else $error("direction changed unasked");

    read_valid_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd
            |=> bus_rvalid ##1 (!bus_rvalid || $past(bus_req.rd)))
        else $error("read valid timing");

    idle_rdata_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !bus_req.rd
            |=> !bus_rvalid && bus_rdata == 8'h00)
        else $error("idle read data not cleared");

    unmap_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr != PRT_DATA_ADDR
            && bus_req.addr != PRT_DIR_ADDR
            |=> bus_rdata == PRT_UNMAP_READ)
        else $error("unmapped read value wrong");

    ////////////////////////////////////////////////////////////////////
    // Scenario covers
    rmw_data_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DATA_ADDR
            ##1 bus_req.wr && bus_req.addr == PRT_DATA_ADDR);
    rmw_dir_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DIR_ADDR
            ##1 bus_req.wr && bus_req.addr == PRT_DIR_ADDR);
    mixed_dir_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        port_three_direction_reg == 8'h3F && bus_req.rd);
    input_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == PRT_DATA_ADDR
            && (pin_sync & ~port_three_direction_reg) != 8'h00);
    unmap_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr != PRT_DATA_ADDR
            && bus_req.addr != PRT_DIR_ADDR);
endmodule

// >>> prt_sync.sv
// Two-stage synchroniser for the sensed pin levels
`timescale 1ns/1ps
module prt_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // A zero-width bank has nothing to carry
    if (WIDTH < 1)
    begin : g_width_check
        $error("synchroniser width must be positive");
    end

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// >>> testbench.sv
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
module testbench;
    import prt_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    prt_req_s    bus_req;
    logic [7:0]  bus_rdata;
    logic        bus_rvalid;
    logic [7:0]  pin_in;
    logic [7:0]  drive;
    prt_pin_s    pin_out;
    int          fail_count;
    int          n_tests;
    logic [31:0] seed;
    logic [7:0]  m_latch;
    logic [7:0]  m_dir;
    logic [7:0]  rv;
    logic [7:0]  exp_q[$];
    ////////////////////////////////////////////////////////////////////
    prt_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .port_three_pin_in(pin_in), .port_three_pin_out(pin_out));
    prt_board board_u (.pin_out(pin_out), .board_drive(drive),
        .pin_in(pin_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches=%0d compares=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Pseudo-random source for pin levels and register values
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    // Inputs change at the falling edge only; a request stands until the
    // next call replaces it, so no strobe is written twice in one step
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge sys_clk);
        if (a == PRT_DATA_ADDR)
            m_latch = d;
        if (a == PRT_DIR_ADDR)
            m_dir = d;
        check(pin_out.oe, m_dir);
        check(pin_out.level, m_latch & m_dir);
    endtask
    // Read answer stands one cycle, so it is taken at once
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        if (a == PRT_DATA_ADDR)
            exp_q.push_back((m_dir & m_latch) | (~m_dir & drive));
        else if (a == PRT_DIR_ADDR)
            exp_q.push_back(PRT_DIR_READ);
        else
            exp_q.push_back(PRT_UNMAP_READ);
        @(negedge sys_clk);
        check({7'h00, bus_rvalid}, 8'h01);
        d = bus_rdata;
        check(d, exp_q.pop_front());
    endtask
    task automatic idle(input int n);
        bus_req = '0;
        repeat (n) @(negedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        bus_req = '0;
        drive = 8'h40;
        seed = 32'h12d0;
        fail_count = 0;
        n_tests = 0;
        m_latch = PRT_DATA_RESET;
        m_dir = PRT_DIR_RESET;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        // Set-bit on data copies input levels into the latch
        write(PRT_DIR_ADDR, 8'h3F);
        write(PRT_DATA_ADDR, 8'h80);
        idle(3);
        rd(PRT_DATA_ADDR, rv);
        check(rv, 8'h40);
        write(PRT_DATA_ADDR, rv | 8'h01);
        // Clear-bit on direction turns inputs into outputs
        rd(PRT_DIR_ADDR, rv);
        write(PRT_DIR_ADDR, rv & 8'hFE);
        check(pin_out.oe, 8'hFE);
        check(pin_out.level, 8'h40);
        // Shadow copy keeps the intended bits
        write(PRT_DIR_ADDR, 8'h3E);
        write(PRT_DATA_ADDR, 8'h81);
        repeat (200)
        begin
            seed = xorshift(seed);
            drive = seed[7:0];
            write(PRT_DIR_ADDR, seed[15:8]);
            write(PRT_DATA_ADDR, seed[23:16]);
            write(16'hFFD7, seed[31:24]);
            // Pin levels need two edges through the synchroniser
            idle(3);
            rd(PRT_DATA_ADDR, rv);
            rd(PRT_DIR_ADDR, rv);
            rd(16'hFFD5, rv);
        end
        finish_test();
    end
    initial
    begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule
